/* File: pkg/sysctl_guard_pkg.sv */
// Constants, register selectors and carriers for the system control register access guard.
// Assumes the pipeline presents one decoded coprocessor access per cycle with its mode; the world comes from the select bit.
// What this block does
// - Banked registers hold separate Secure and Non-secure copies chosen by the select bit.
// - Refused accesses raise undefined-instruction and leave the register unchanged.
// - Some control register bits are shared by both copies.
// - Cache dirty status is read-only; other banked registers read/write when privileged.
// - Non-secure writes never change Secure-only registers or Secure banked copies.
// - Non-secure access permissions: Non-secure privileged read, Secure privileged write only.
// - Other Secure-only registers are unreadable from any Non-secure mode.
// - Permission bits 15:14 are unused; system and debug coprocessors are not gated.
// - Access bit 0 limits to Secure privileged; 1 allows all privileged modes.
// - A restricted register governed by one bit is undefined on any access.
// - Restricted parts of a multi-bit-governed register read zero and ignore writes.
// - Bits 13:0 gate coprocessor access control; bit 16 cache lockdown; bit 17 TLB lockdown.
// - Bit 18 gates DMA control; TCM permission bit 0 gates each TCM region.
// - While the lock input is high, writes to locked Secure registers are undefined.
// - The lock never affects reads, nor Non-secure register accesses.
// - Lock changes take effect quickly, at the latest after a pipeline flush.
// - Lock covers control, translation base, control, domain, vector bases, process ID writes.
// - Lock covers TCM permission registers, and TCM regions only while restricted.
// - Secure configuration register is Secure-only and separate from the Secure control copy.
// - Select bit picks copies for explicit accesses; usage follows the request's world.
// - User mode accesses are undefined except flush, barrier and user-enabled DMA.
// - Select bit is bit 0 of secure configuration; monitor mode is always Secure.
package sysctl_guard_pkg;
	localparam int DATA_W = 32;
	typedef enum logic [4:0] {
		SEL_CONTROL = 5'h00, SEL_AUX_CONTROL = 5'h01, SEL_CP_ACCESS = 5'h02, SEL_SEC_CONFIG = 5'h03,
		SEL_SEC_DEBUG = 5'h04, SEL_NS_PERMS = 5'h05, SEL_TRANS_BASE0 = 5'h06, SEL_TRANS_CTRL = 5'h07,
		SEL_DOMAIN = 5'h08, SEL_DIRTY_STATUS = 5'h09, SEL_WATCH_FAULT = 5'h0a, SEL_DTCM_REGION = 5'h0b,
		SEL_ITCM_REGION = 5'h0c, SEL_DTCM_PERM = 5'h0d, SEL_ITCM_PERM = 5'h0e, SEL_DCACHE_LOCK = 5'h0f,
		SEL_ICACHE_LOCK = 5'h10, SEL_TLB_LOCK = 5'h11, SEL_DMA_CTRL = 5'h12, SEL_VECTOR_BASE = 5'h13,
		SEL_MONITOR_BASE = 5'h14, SEL_PROCESS_ID = 5'h15, SEL_TCM_SELECT = 5'h16, SEL_FLUSH = 5'h17,
		SEL_BARRIER = 5'h18
	} reg_sel_t;
	typedef enum logic [1:0] {MODE_USER = 2'h0, MODE_PRIV = 2'h1, MODE_MONITOR = 2'h2} cpu_mode_t;
	typedef struct packed {
		logic valid;
		logic write;
		reg_sel_t sel;
		cpu_mode_t mode;
		logic [DATA_W-1:0] wdata;
	} access_req_t;
	typedef struct packed {
		logic valid;
		logic undef;
		logic [DATA_W-1:0] rdata;
	} access_rsp_t;
	localparam int SELECT_BIT = 0;
	localparam int NSP_CP_ACCESS_MSB = 13;
	localparam int NSP_CACHE_LOCK_BIT = 16;
	localparam int NSP_TLB_LOCK_BIT = 17;
	localparam int NSP_DMA_BIT = 18;
	localparam int TCM_PERM_BIT = 0;
	localparam int CP_FIELD_W = 2;
	localparam logic [DATA_W-1:0] NSP_WRITE_MASK = 32'h0007_3fff;
	localparam logic [DATA_W-1:0] TCM_PERM_MASK = 32'h0000_0001;
	localparam logic [DATA_W-1:0] CTRL_SHARED_MASK = 32'h0000_2480;
	localparam logic [DATA_W-1:0] SEC_CONFIG_MASK = 32'h0000_007f;
	localparam logic [DATA_W-1:0] RESET_ZERO = 32'h0000_0000;
endpackage

/* File: hw/sysctl_guard.sv */
// Access guard and register store for the security-sensitive system control registers.
// Assumes the pipeline holds one access per cycle and routes the undefined flag to exception logic.
`timescale 1ns/1ps
`default_nettype none
module sysctl_guard #(
	parameter int DATA_W = 32
) (
	input wire logic clk,
	input wire logic resetn,
	input wire sysctl_guard_pkg::access_req_t req,
	input wire logic secure_write_lock_input,
	output sysctl_guard_pkg::access_rsp_t rsp,
	output logic security_select_bit,
	output logic [DATA_W-1:0] control_secure,
	output logic [DATA_W-1:0] control_nonsecure,
	output logic dma_access_permission_bit,
	output logic data_tcm_permission_bit,
	output logic instr_tcm_permission_bit
);
	import sysctl_guard_pkg::*;

	initial begin
		if (DATA_W != 32) begin
			$error("sysctl_guard supports only 32-bit data");
		end
	end

	// The lock pin comes from a separate security block, so it is synchronised; two cycles is well
	// inside the flush window that software must issue after changing it.
	logic lock_meta_reg;
	logic lock_sync_reg;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lock_meta_reg <= 1'b0;
			lock_sync_reg <= 1'b0;
		end else begin
			lock_meta_reg <= secure_write_lock_input;
			lock_sync_reg <= lock_meta_reg;
		end
	end

	// Secure-only and common registers, one copy each.
	logic [DATA_W-1:0] sec_config_reg;
	logic [DATA_W-1:0] sec_debug_reg;
	logic [DATA_W-1:0] ns_perms_reg;
	logic [DATA_W-1:0] dtcm_perm_reg;
	logic [DATA_W-1:0] itcm_perm_reg;
	logic [DATA_W-1:0] watch_fault_reg;
	logic [DATA_W-1:0] monitor_base_reg;
	logic [DATA_W-1:0] cp_access_reg;
	logic [DATA_W-1:0] dtcm_region_reg;
	logic [DATA_W-1:0] itcm_region_reg;
	logic [DATA_W-1:0] dcache_lock_reg;
	logic [DATA_W-1:0] icache_lock_reg;
	logic [DATA_W-1:0] tlb_lock_reg;
	logic [DATA_W-1:0] dma_ctrl_reg;
	// Banked registers: index 0 is the Secure copy, index 1 the Non-secure copy.
	logic [DATA_W-1:0] ctrl_bank_reg [2];
	logic [DATA_W-1:0] aux_bank_reg [2];
	logic [DATA_W-1:0] tbase_bank_reg [2];
	logic [DATA_W-1:0] tctrl_bank_reg [2];
	logic [DATA_W-1:0] domain_bank_reg [2];
	logic [DATA_W-1:0] vbase_bank_reg [2];
	logic [DATA_W-1:0] pid_bank_reg [2];
	logic [DATA_W-1:0] tcmsel_bank_reg [2];
	logic [DATA_W-1:0] ctrl_shared_reg;

	wire is_monitor = (req.mode == MODE_MONITOR);
	wire is_user = (req.mode == MODE_USER);
	wire sel_bit = sec_config_reg[SELECT_BIT];
	wire world_ns = sel_bit && !is_monitor;
	// Monitor mode reaches the copy named by the select bit.
	wire bank = sel_bit;
	wire sec_priv = !is_user && !world_ns;
	wire ns_priv = !is_user && world_ns;

	wire sel_banked = (req.sel == SEL_CONTROL) ||
		(req.sel == SEL_AUX_CONTROL) ||
		(req.sel == SEL_TRANS_BASE0) ||
		(req.sel == SEL_TRANS_CTRL) ||
		(req.sel == SEL_DOMAIN) ||
		(req.sel == SEL_DIRTY_STATUS) ||
		(req.sel == SEL_VECTOR_BASE) ||
		(req.sel == SEL_PROCESS_ID) ||
		(req.sel == SEL_TCM_SELECT);
	wire sel_secure_only = (req.sel == SEL_SEC_CONFIG) ||
		(req.sel == SEL_SEC_DEBUG) ||
		(req.sel == SEL_WATCH_FAULT) ||
		(req.sel == SEL_DTCM_PERM) ||
		(req.sel == SEL_ITCM_PERM) ||
		(req.sel == SEL_MONITOR_BASE);
	wire nsp_dtcm = dtcm_perm_reg[TCM_PERM_BIT];
	wire nsp_itcm = itcm_perm_reg[TCM_PERM_BIT];
	wire nsp_cache = ns_perms_reg[NSP_CACHE_LOCK_BIT];
	wire nsp_tlb = ns_perms_reg[NSP_TLB_LOCK_BIT];
	wire nsp_dma = ns_perms_reg[NSP_DMA_BIT];
	// Single-bit governed registers: allowed when Secure privileged or the bit is set.
	wire single_gate = (req.sel == SEL_DTCM_REGION) ? nsp_dtcm :
		(req.sel == SEL_ITCM_REGION) ? nsp_itcm :
		((req.sel == SEL_DCACHE_LOCK) || (req.sel == SEL_ICACHE_LOCK)) ? nsp_cache :
		(req.sel == SEL_TLB_LOCK) ? nsp_tlb :
		(req.sel == SEL_DMA_CTRL) ? nsp_dma : 1'b1;
	wire sel_single = (req.sel == SEL_DTCM_REGION) ||
		(req.sel == SEL_ITCM_REGION) ||
		(req.sel == SEL_DCACHE_LOCK) ||
		(req.sel == SEL_ICACHE_LOCK) ||
		(req.sel == SEL_TLB_LOCK) ||
		(req.sel == SEL_DMA_CTRL);
	// Per-field mask of the coprocessor access register open to Non-secure, two bits per coprocessor.
	logic [DATA_W-1:0] cp_open_mask;
	always_comb begin
		cp_open_mask = RESET_ZERO;
		for (int i = 0; i <= NSP_CP_ACCESS_MSB; i++) begin
			cp_open_mask[i*CP_FIELD_W +: CP_FIELD_W] = {CP_FIELD_W{ns_perms_reg[i] || !world_ns}};
		end
	end

	wire user_ok = (req.sel == SEL_FLUSH) || (req.sel == SEL_BARRIER) ||
		((req.sel == SEL_DMA_CTRL) && dma_ctrl_reg[0] && (!world_ns || nsp_dma));
	// Only the Secure copy is locked, so monitor code can still set up the Non-secure side.
	wire lock_target = (req.sel == SEL_CONTROL) ||
		(req.sel == SEL_TRANS_BASE0) ||
		(req.sel == SEL_TRANS_CTRL) ||
		(req.sel == SEL_DOMAIN) ||
		(req.sel == SEL_VECTOR_BASE) ||
		(req.sel == SEL_PROCESS_ID);
	wire lock_hit = lock_sync_reg && req.write && !world_ns && (((lock_target && !bank) ||
		(req.sel == SEL_MONITOR_BASE) || (req.sel == SEL_DTCM_PERM) || (req.sel == SEL_ITCM_PERM)) ||
		((req.sel == SEL_DTCM_REGION) && !nsp_dtcm) || ((req.sel == SEL_ITCM_REGION) && !nsp_itcm));

	logic refuse;
	always_comb begin
		refuse = 1'b0;
		if (is_user) begin
			refuse = !user_ok;
		end else if (req.sel == SEL_NS_PERMS) begin
			refuse = world_ns && req.write;
		end else if (sel_secure_only) begin
			refuse = world_ns;
		end else if (sel_single) begin
			refuse = world_ns && !single_gate;
		end else if (req.sel == SEL_DIRTY_STATUS) begin
			refuse = req.write;
		end
	end
	wire undef_now = req.valid && (refuse || lock_hit);
	wire do_write = req.valid && req.write && !undef_now;
	wire [DATA_W-1:0] wd = req.wdata;
	wire [DATA_W-1:0] ctrl_view = (ctrl_bank_reg[bank] & ~CTRL_SHARED_MASK) | (ctrl_shared_reg & CTRL_SHARED_MASK);

	logic [DATA_W-1:0] rd;
	always_comb begin
		case (req.sel)
			SEL_CONTROL: rd = ctrl_view;
			SEL_AUX_CONTROL: rd = aux_bank_reg[bank];
			SEL_CP_ACCESS: rd = cp_access_reg & cp_open_mask;
			SEL_SEC_CONFIG: rd = sec_config_reg;
			SEL_SEC_DEBUG: rd = sec_debug_reg;
			SEL_NS_PERMS: rd = ns_perms_reg;
			SEL_TRANS_BASE0: rd = tbase_bank_reg[bank];
			SEL_TRANS_CTRL: rd = tctrl_bank_reg[bank];
			SEL_DOMAIN: rd = domain_bank_reg[bank];
			SEL_WATCH_FAULT: rd = watch_fault_reg;
			SEL_DTCM_REGION: rd = dtcm_region_reg;
			SEL_ITCM_REGION: rd = itcm_region_reg;
			SEL_DTCM_PERM: rd = dtcm_perm_reg;
			SEL_ITCM_PERM: rd = itcm_perm_reg;
			SEL_DCACHE_LOCK: rd = dcache_lock_reg;
			SEL_ICACHE_LOCK: rd = icache_lock_reg;
			SEL_TLB_LOCK: rd = tlb_lock_reg;
			SEL_DMA_CTRL: rd = dma_ctrl_reg;
			SEL_VECTOR_BASE: rd = vbase_bank_reg[bank];
			SEL_MONITOR_BASE: rd = monitor_base_reg;
			SEL_PROCESS_ID: rd = pid_bank_reg[bank];
			SEL_TCM_SELECT: rd = tcmsel_bank_reg[bank];
			default: rd = RESET_ZERO;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rsp <= '0;
		end else begin
			rsp.valid <= req.valid;
			rsp.undef <= undef_now;
			rsp.rdata <= (req.valid && !req.write && !undef_now) ? rd : RESET_ZERO;
		end
	end

	// Non-secure writes to the shared control bits are dropped: they are Secure-owned.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sec_config_reg <= RESET_ZERO;
			sec_debug_reg <= RESET_ZERO;
			ns_perms_reg <= RESET_ZERO;
			dtcm_perm_reg <= RESET_ZERO;
			itcm_perm_reg <= RESET_ZERO;
			watch_fault_reg <= RESET_ZERO;
			monitor_base_reg <= RESET_ZERO;
			cp_access_reg <= RESET_ZERO;
			dtcm_region_reg <= RESET_ZERO;
			itcm_region_reg <= RESET_ZERO;
			dcache_lock_reg <= RESET_ZERO;
			icache_lock_reg <= RESET_ZERO;
			tlb_lock_reg <= RESET_ZERO;
			dma_ctrl_reg <= RESET_ZERO;
			ctrl_shared_reg <= RESET_ZERO;
			for (int b = 0; b < 2; b++) begin
				ctrl_bank_reg[b] <= RESET_ZERO;
				aux_bank_reg[b] <= RESET_ZERO;
				tbase_bank_reg[b] <= RESET_ZERO;
				tctrl_bank_reg[b] <= RESET_ZERO;
				domain_bank_reg[b] <= RESET_ZERO;
				vbase_bank_reg[b] <= RESET_ZERO;
				pid_bank_reg[b] <= RESET_ZERO;
				tcmsel_bank_reg[b] <= RESET_ZERO;
			end
		end else if (do_write) begin
			case (req.sel)
				SEL_CONTROL: begin
					ctrl_bank_reg[bank] <= wd;
					if (!world_ns) begin
						ctrl_shared_reg <= wd & CTRL_SHARED_MASK;
					end
				end
				SEL_AUX_CONTROL: aux_bank_reg[bank] <= wd;
				SEL_CP_ACCESS: cp_access_reg <= (cp_access_reg & ~cp_open_mask) | (wd & cp_open_mask);
				SEL_SEC_CONFIG: sec_config_reg <= wd & SEC_CONFIG_MASK;
				SEL_SEC_DEBUG: sec_debug_reg <= wd;
				SEL_NS_PERMS: ns_perms_reg <= wd & NSP_WRITE_MASK;
				SEL_TRANS_BASE0: tbase_bank_reg[bank] <= wd;
				SEL_TRANS_CTRL: tctrl_bank_reg[bank] <= wd;
				SEL_DOMAIN: domain_bank_reg[bank] <= wd;
				SEL_WATCH_FAULT: watch_fault_reg <= wd;
				SEL_DTCM_REGION: dtcm_region_reg <= wd;
				SEL_ITCM_REGION: itcm_region_reg <= wd;
				SEL_DTCM_PERM: dtcm_perm_reg <= wd & TCM_PERM_MASK;
				SEL_ITCM_PERM: itcm_perm_reg <= wd & TCM_PERM_MASK;
				SEL_DCACHE_LOCK: dcache_lock_reg <= wd;
				SEL_ICACHE_LOCK: icache_lock_reg <= wd;
				SEL_TLB_LOCK: tlb_lock_reg <= wd;
				SEL_DMA_CTRL: dma_ctrl_reg <= wd;
				SEL_VECTOR_BASE: vbase_bank_reg[bank] <= wd;
				SEL_MONITOR_BASE: monitor_base_reg <= wd;
				SEL_PROCESS_ID: pid_bank_reg[bank] <= wd;
				SEL_TCM_SELECT: tcmsel_bank_reg[bank] <= wd;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			security_select_bit <= 1'b0;
			control_secure <= RESET_ZERO;
			control_nonsecure <= RESET_ZERO;
			dma_access_permission_bit <= 1'b0;
			data_tcm_permission_bit <= 1'b0;
			instr_tcm_permission_bit <= 1'b0;
		end else begin
			security_select_bit <= sel_bit;
			control_secure <= (ctrl_bank_reg[0] & ~CTRL_SHARED_MASK) | ctrl_shared_reg;
			control_nonsecure <= (ctrl_bank_reg[1] & ~CTRL_SHARED_MASK) | ctrl_shared_reg;
			dma_access_permission_bit <= nsp_dma;
			data_tcm_permission_bit <= nsp_dtcm;
			instr_tcm_permission_bit <= nsp_itcm;
		end
	end

	a_user_refused: assert property (@(posedge clk) disable iff (!resetn)
		req.valid && is_user && (req.sel == SEL_CONTROL) |=> rsp.undef) else $error("user control access not refused");
	a_ns_secure_read: assert property (@(posedge clk) disable iff (!resetn)
		req.valid && ns_priv && (req.sel == SEL_SEC_CONFIG) |=> rsp.undef && rsp.rdata == 32'h0) else $error("secure read leaked");
	a_perms_ns_read: assert property (@(posedge clk) disable iff (!resetn)
		req.valid && ns_priv && (req.sel == SEL_NS_PERMS) |=> rsp.undef == $past(req.write)) else $error("permission register access wrong");
	a_dirty_readonly: assert property (@(posedge clk) disable iff (!resetn)
		req.valid && !is_user && req.write && (req.sel == SEL_DIRTY_STATUS) |=> rsp.undef) else $error("dirty status write allowed");
	a_lock_blocks: assert property (@(posedge clk) disable iff (!resetn)
		lock_sync_reg && req.valid && sec_priv && req.write && (req.sel == SEL_MONITOR_BASE)
		|=> rsp.undef && $stable(monitor_base_reg)) else $error("locked write not refused");
	a_lock_read_free: assert property (@(posedge clk) disable iff (!resetn)
		req.valid && sec_priv && !req.write && (req.sel == SEL_MONITOR_BASE) |=> !rsp.undef) else $error("lock affected a read");
	a_lock_latency: assert property (@(posedge clk) disable iff (!resetn)
		$rose(secure_write_lock_input) ##1 secure_write_lock_input |=> lock_sync_reg) else $error("lock too slow");
	a_tcm_region_gate: assert property (@(posedge clk) disable iff (!resetn)
		req.valid && ns_priv && (req.sel == SEL_DTCM_REGION) |=> rsp.undef == !$past(nsp_dtcm)) else $error("tcm region gate wrong");
	a_ns_no_secure_copy: assert property (@(posedge clk) disable iff (!resetn)
		req.valid && world_ns && req.write && (req.sel == SEL_TRANS_BASE0) |=> $stable(tbase_bank_reg[0])) else $error("secure copy changed");
	a_sec_debug_hidden: assert property (@(posedge clk) disable iff (!resetn)
		req.valid && ns_priv && (req.sel == SEL_SEC_DEBUG)
		|=> rsp.undef) else $error("secure debug access from non-secure");
	a_watch_hidden: assert property (@(posedge clk) disable iff (!resetn)
		req.valid && ns_priv && (req.sel == SEL_WATCH_FAULT)
		|=> rsp.undef) else $error("watchpoint fault access from non-secure");
	a_config_ns_write: assert property (@(posedge clk) disable iff (!resetn)
		req.valid && world_ns && req.write && (req.sel == SEL_SEC_CONFIG)
		|=> $stable(sec_config_reg)) else $error("secure config changed from non-secure");
	a_perms_unused_bits: assert property (@(posedge clk) disable iff (!resetn)
		req.valid && sec_priv && req.write && (req.sel == SEL_NS_PERMS)
		|=> !rsp.undef && (ns_perms_reg[15:14] == 2'h0)) else $error("unused permission bits set");
	a_cache_lock_gate: assert property (@(posedge clk) disable iff (!resetn)
		req.valid && ns_priv && (req.sel == SEL_DCACHE_LOCK)
		|=> rsp.undef == !$past(nsp_cache)) else $error("cache lockdown gate wrong");
	a_tlb_lock_gate: assert property (@(posedge clk) disable iff (!resetn)
		req.valid && ns_priv && (req.sel == SEL_TLB_LOCK)
		|=> rsp.undef == !$past(nsp_tlb)) else $error("tlb lockdown gate wrong");
	a_dma_gate: assert property (@(posedge clk) disable iff (!resetn)
		req.valid && ns_priv && (req.sel == SEL_DMA_CTRL)
		|=> rsp.undef == !$past(nsp_dma)) else $error("dma control gate wrong");
	a_itcm_region_gate: assert property (@(posedge clk) disable iff (!resetn)
		req.valid && ns_priv && (req.sel == SEL_ITCM_REGION)
		|=> rsp.undef == !$past(nsp_itcm)) else $error("instruction tcm region gate wrong");
	a_secure_priv_open: assert property (@(posedge clk) disable iff (!resetn)
		req.valid && sec_priv && sel_single && !lock_sync_reg
		|=> !rsp.undef) else $error("secure privileged access refused");
	a_cp_partial_mask: assert property (@(posedge clk) disable iff (!resetn)
		req.valid && ns_priv && !req.write && (req.sel == SEL_CP_ACCESS)
		|=> !rsp.undef && ((rsp.rdata & ~$past(cp_open_mask)) == RESET_ZERO)) else $error("closed field read");
	a_lock_tcm_perm: assert property (@(posedge clk) disable iff (!resetn)
		lock_sync_reg && req.valid && sec_priv && req.write && (req.sel == SEL_DTCM_PERM)
		|=> rsp.undef) else $error("locked tcm permission write allowed");
	a_lock_ns_free: assert property (@(posedge clk) disable iff (!resetn)
		lock_sync_reg && req.valid && ns_priv && req.write && (req.sel == SEL_CONTROL)
		|=> !rsp.undef) else $error("lock refused a non-secure write");
	a_lock_control: assert property (@(posedge clk) disable iff (!resetn)
		lock_sync_reg && req.valid && sec_priv && !bank && req.write && (req.sel == SEL_CONTROL)
		|=> rsp.undef) else $error("locked control write allowed");
	a_shared_ns_write: assert property (@(posedge clk) disable iff (!resetn)
		req.valid && ns_priv && req.write && (req.sel == SEL_CONTROL)
		|=> $stable(ctrl_shared_reg)) else $error("shared control bits changed from non-secure");
	a_undef_no_write: assert property (@(posedge clk) disable iff (!resetn)
		req.valid && req.write && undef_now && (req.sel == SEL_DOMAIN)
		|=> $stable(domain_bank_reg[0]) && $stable(domain_bank_reg[1])) else $error("refused write landed");
	a_rsp_follows: assert property (@(posedge clk) disable iff (!resetn)
		req.valid
		|=> rsp.valid) else $error("answer missing");
	a_monitor_bank: assert property (@(posedge clk) disable iff (!resetn)
		req.valid && is_monitor && !req.write && (req.sel == SEL_TRANS_BASE0)
		|=> rsp.rdata == $past(tbase_bank_reg[bank])) else $error("monitor read wrong copy");
	c_monitor_ns_write: cover property (@(posedge clk) req.valid && is_monitor && sel_bit && req.write && do_write);
	c_banked_ns_read: cover property (@(posedge clk) req.valid && ns_priv && sel_banked && !req.write);
	c_lock_refusal: cover property (@(posedge clk) lock_hit && req.valid);
	c_cp_partial: cover property (@(posedge clk) req.valid && ns_priv && (req.sel == SEL_CP_ACCESS) && ns_perms_reg[0]);
endmodule
`default_nettype wire

/* File: testbench/lock_controller_model.sv */
// Model of the system security block that drives the secure write lock.
// Assumes the bench commands the lock level and keeps its own traffic quiet after a change.
`timescale 1ns/1ps
`default_nettype none
module lock_controller_model (
	input wire logic resetn,
	input wire logic lock_cmd,
	output logic secure_write_lock_input
);
	// The lock is forced low in reset so boot code can set up the secure side before locking.
	assign secure_write_lock_input = resetn & lock_cmd;
endmodule
`default_nettype wire

/* File: testbench/secure_sysctl_register_access_guard_tb.sv */
// Self-checking bench for the access guard, with an integer and queue model of the registers.
// Assumes one access per cycle, answers one cycle after the taking edge, lock effective two edges on.
`timescale 1ns/1ps
`default_nettype none
module secure_sysctl_register_access_guard_tb;
	import sysctl_guard_pkg::*;
	typedef struct packed {logic v; logic u; logic [31:0] rd; logic [31:0] cs; logic [31:0] cn; logic [3:0] b;} exp_t;
	logic clk = 0, resetn = 0, lock_cmd = 0, lock_m = 0;
	logic lock, sb, db, tb, ib;
	logic [31:0] cs, cn;
	access_req_t req = '0;
	access_rsp_t rsp;
	int fail_count = 0, tests_run = 0;
	logic [31:0] st[2][32];
	exp_t exp_q[$];
	exp_t last_e = '0;
	reg_sel_t sels[17] = '{SEL_CONTROL, SEL_TRANS_BASE0, SEL_TRANS_CTRL, SEL_DOMAIN, SEL_VECTOR_BASE, SEL_PROCESS_ID,
		SEL_SEC_CONFIG, SEL_NS_PERMS, SEL_DTCM_PERM, SEL_ITCM_PERM, SEL_DTCM_REGION, SEL_ITCM_REGION,
		SEL_MONITOR_BASE, SEL_DIRTY_STATUS, SEL_TLB_LOCK, SEL_DMA_CTRL, SEL_FLUSH};
	lock_controller_model u_lock (.resetn(resetn), .lock_cmd(lock_cmd), .secure_write_lock_input(lock));
	sysctl_guard #(.DATA_W(DATA_W)) u_dut (.clk(clk), .resetn(resetn), .req(req), .secure_write_lock_input(lock),
		.rsp(rsp), .security_select_bit(sb), .control_secure(cs), .control_nonsecure(cn),
		.dma_access_permission_bit(db), .data_tcm_permission_bit(tb), .instr_tcm_permission_bit(ib));
	initial begin
		forever #5 clk = ~clk;
	end
	function automatic logic world_ns(cpu_mode_t m);
		return m != MODE_MONITOR && st[0][SEL_SEC_CONFIG][0];
	endfunction
	function automatic logic refused(logic w, reg_sel_t s, cpu_mode_t m, logic ns, logic bk);
		logic [31:0] p;
		logic dt, it;
		p = st[0][SEL_NS_PERMS];
		dt = st[0][SEL_DTCM_PERM][0];
		it = st[0][SEL_ITCM_PERM][0];
		if (m == MODE_USER)
			return !(s == SEL_FLUSH || (s == SEL_DMA_CTRL && st[0][SEL_DMA_CTRL][0] && (!ns || p[18])));
		if (ns && (s inside {SEL_SEC_CONFIG, SEL_DTCM_PERM, SEL_ITCM_PERM, SEL_MONITOR_BASE} || (w && s == SEL_NS_PERMS)))
			return 1;
		if (ns && ((s == SEL_DTCM_REGION && !dt) || (s == SEL_ITCM_REGION && !it) || (s == SEL_TLB_LOCK && !p[17])
			|| (s == SEL_DMA_CTRL && !p[18])))
			return 1;
		if (w && s == SEL_DIRTY_STATUS)
			return 1;
		return w && lock_m && ((!bk && s inside {SEL_CONTROL, SEL_TRANS_BASE0, SEL_TRANS_CTRL, SEL_DOMAIN,
			SEL_VECTOR_BASE, SEL_PROCESS_ID}) || s inside {SEL_MONITOR_BASE, SEL_DTCM_PERM, SEL_ITCM_PERM}
			|| (s == SEL_DTCM_REGION && !dt) || (s == SEL_ITCM_REGION && !it));
	endfunction
	function automatic exp_t views();
		exp_t e;
		e = '0;
		e.cs = st[0][SEL_CONTROL];
		e.cn = st[1][SEL_CONTROL];
		e.b = {st[0][SEL_SEC_CONFIG][0], st[0][SEL_NS_PERMS][18], st[0][SEL_DTCM_PERM][0], st[0][SEL_ITCM_PERM][0]};
		return e;
	endfunction
	task automatic check_bit(input string n, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic check_word(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic compare(input exp_t e);
		check_bit("rsp.valid", e.v, rsp.valid);
		if (e.v) begin
			check_bit("rsp.undef", e.u, rsp.undef);
			check_word("rsp.rdata", e.rd, rsp.rdata);
		end
		// The state views are registered from the stores, so they trail the answer by one cycle.
		check_word("control_secure", last_e.cs, cs);
		check_word("control_nonsecure", last_e.cn, cn);
		check_word("status bits", {28'h0000000, last_e.b}, {28'h0000000, sb, db, tb, ib});
		last_e = e;
	endtask
	task automatic drive(input access_req_t r, input exp_t e);
		@(posedge clk);
		req <= r;
		lock_cmd <= lock_m;
		#1;
		if (exp_q.size() > 0)
			compare(exp_q.pop_front());
		exp_q.push_back(e);
	endtask
	task automatic access(input logic w, input reg_sel_t s, input cpu_mode_t m, input logic [31:0] d);
		exp_t e;
		access_req_t r;
		logic u, ns, bk, b;
		logic [31:0] k;
		ns = world_ns(m);
		bk = (m == MODE_MONITOR) ? st[0][SEL_SEC_CONFIG][0] : ns;
		b = (s inside {SEL_CONTROL, SEL_TRANS_BASE0, SEL_TRANS_CTRL, SEL_DOMAIN, SEL_DIRTY_STATUS, SEL_VECTOR_BASE,
			SEL_PROCESS_ID}) ? bk : 1'b0;
		u = refused(w, s, m, ns, bk);
		k = s == SEL_SEC_CONFIG ? SEC_CONFIG_MASK : s == SEL_NS_PERMS ? NSP_WRITE_MASK :
			s inside {SEL_DTCM_PERM, SEL_ITCM_PERM} ? TCM_PERM_MASK : s == SEL_FLUSH ? 32'h0000_0000 : 32'hffff_ffff;
		e = '0;
		e.v = 1;
		e.u = u;
		e.rd = (w || u) ? 32'h0000_0000 : st[b][s];
		if (w && !u && s == SEL_CONTROL) begin
			st[b][s] = (d & ~CTRL_SHARED_MASK) | ((ns ? st[b][s] : d) & CTRL_SHARED_MASK);
			if (!ns)
				st[!b][s] = (st[!b][s] & ~CTRL_SHARED_MASK) | (d & CTRL_SHARED_MASK);
		end else if (w && !u)
			st[b][s] = d & k;
		e = '{e.v, e.u, e.rd, views().cs, views().cn, views().b};
		r = '0;
		r.valid = 1;
		r.write = w;
		r.sel = s;
		r.mode = m;
		r.wdata = d;
		drive(r, e);
	endtask
	task automatic set_lock(input logic v);
		lock_m = v;
		// Quiet cycles stand in for the pipeline flush that makes the new lock level certain.
		repeat (4) drive('0, views());
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge clk);
		fail_count++;
		$display("Error watchdog expired");
		conclude();
	end
	initial begin
		foreach (st[i, j])
			st[i][j] = 32'h0000_0000;
		void'($urandom(32'h94a9150f));
		repeat (16) @(posedge clk);
		resetn <= 1;
		// Each of the 17 selectors in sels, every direction and mode, in both worlds, with the lock low and then high.
		for (int lk = 0; lk < 2; lk++) begin
			for (int sc = 0; sc < 2; sc++) begin
				access(1, SEL_SEC_CONFIG, MODE_MONITOR, 32'(sc));
				foreach (sels[i])
					for (int m = 0; m < 3; m++)
						for (int w = 0; w < 2; w++)
							access(w[0], sels[i], cpu_mode_t'(m), $urandom());
			end
			$display("test sweep lock %0d done", lk);
			set_lock(!lk[0]);
		end
		for (int n = 0; n < 400; n++) begin
			if (n % 50 == 49)
				set_lock($urandom_range(1));
			access($urandom_range(1), sels[$urandom_range(16)], cpu_mode_t'($urandom_range(2)), $urandom());
		end
		drive('0, views());
		drive('0, views());
		$display("test random traffic done");
		conclude();
	end
endmodule
`default_nettype wire
